// ===== logic/sbl_bank.sv
// Module: device-side register bank with gain-band bits and lock status word
`timescale 1ns/1ns

// Summary of operation
// - Host sets first band bit from code
// - Host sets second band bit from code
// - Band bits reset to zero
// - Host read-modify-writes band registers
// - Host preserves factory bits and words
// - Bit 23 shows second loop lock
// - Bit 21 shows first loop lock
// - Status word ignores host writes
// - Bits 18:17 carry variant subcode
module sbl_bank #(
  parameter logic [1:0] SUBCODE = sbl_pkg::SUBCODE_DEFAULT
) (
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  sbl_if.dev        bus,
  input  wire logic first_loop_locked_flag_in,
  input  wire logic second_loop_locked_flag_in,
  output logic      first_loop_gain_band_bit_out,
  output logic      second_loop_gain_band_bit_out
);
  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic        first_band_reg;
  logic        second_band_reg;
  logic [30:0] first_low_reg;
  logic [30:0] second_low_reg;
  logic [31:0] factory_a_reg;
  logic [31:0] factory_b_reg;
  logic [31:0] rdata_reg;
  logic        rvalid_reg;
  logic [31:0] status_word;

  // Band bits, held low from reset until the host writes
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      first_band_reg  <= sbl_pkg::BAND_RESET;
      second_band_reg <= sbl_pkg::BAND_RESET;
    end else if (bus.wr_stb) begin
      if (bus.addr == sbl_pkg::ADDR_FIRST_BAND) begin
        first_band_reg <= bus.wdata[sbl_pkg::BAND_BIT];
      end
      if (bus.addr == sbl_pkg::ADDR_SECOND_BAND) begin
        second_band_reg <= bus.wdata[sbl_pkg::BAND_BIT];
      end
    end
  end

  // Factory bits stay writable; the host is trusted to write them back unchanged
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      first_low_reg  <= sbl_pkg::BAND_LOW_DEFAULT;
      second_low_reg <= sbl_pkg::BAND_LOW_DEFAULT;
      factory_a_reg  <= sbl_pkg::FACTORY_A_DEFAULT;
      factory_b_reg  <= sbl_pkg::FACTORY_B_DEFAULT;
    end else if (bus.wr_stb) begin
      case (bus.addr)
        sbl_pkg::ADDR_FIRST_BAND:     first_low_reg  <= bus.wdata[30:0];
        sbl_pkg::ADDR_SECOND_BAND:    second_low_reg <= bus.wdata[30:0];
        sbl_pkg::ADDR_FACTORY_WORD_A: factory_a_reg  <= bus.wdata;
        sbl_pkg::ADDR_FACTORY_WORD_B: factory_b_reg  <= bus.wdata;
        default: ;  // Status word and unmapped addresses ignore writes
      endcase
    end
  end

  // Live status word built straight from the loop flags
  always_comb begin
    status_word = sbl_pkg::READ_ZERO;
    status_word[sbl_pkg::SECOND_LOCK_BIT] = second_loop_locked_flag_in;
    status_word[sbl_pkg::FIRST_LOCK_BIT]  = first_loop_locked_flag_in;
    status_word[sbl_pkg::SUBCODE_HI:sbl_pkg::SUBCODE_LO] = SUBCODE;
  end

  // Read path: one cycle latency, no flag is cleared by reading
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rdata_reg  <= sbl_pkg::READ_ZERO;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= bus.rd_stb;
      if (bus.rd_stb) begin
        case (bus.addr)
          sbl_pkg::ADDR_FACTORY_WORD_A: rdata_reg <= factory_a_reg;
          sbl_pkg::ADDR_FIRST_BAND:     rdata_reg <= {first_band_reg, first_low_reg};
          sbl_pkg::ADDR_FACTORY_WORD_B: rdata_reg <= factory_b_reg;
          sbl_pkg::ADDR_SECOND_BAND:    rdata_reg <= {second_band_reg, second_low_reg};
          sbl_pkg::ADDR_LOCK_STATUS:    rdata_reg <= status_word;
          default:                      rdata_reg <= sbl_pkg::READ_ZERO;
        endcase
      end
    end
  end

  assign bus.rdata  = rdata_reg;
  assign bus.rvalid = rvalid_reg;
  assign first_loop_gain_band_bit_out  = first_band_reg;
  assign second_loop_gain_band_bit_out = second_band_reg;
endmodule

// ===== logic/sbl_host.sv
// Module: host-side controller that sets a loop's gain band by read-modify-write
`timescale 1ns/1ns
module sbl_host (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  sbl_if.host              bus,
  input  wire logic        band_req_in,
  input  wire logic        loop_sel_in,
  input  wire logic [4:0]  range_code_in,
  input  wire logic        status_req_in,
  output logic             busy_out,
  output logic             done_out,
  output logic             code_err_out,
  output logic             first_loop_locked_flag_out,
  output logic             second_loop_locked_flag_out,
  output logic [1:0]       subcode_out
);
  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {IDLE, RD, RD_WAIT, WR, ST_WAIT} sbl_state_e;
  sbl_state_e  state_reg;
  logic        band_reg;
  logic [4:0]  addr_reg;
  logic        wr_reg;
  logic        rd_reg;
  logic [31:0] wdata_reg;

  // Band choice from the range code; codes above the top are refused
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_reg    <= IDLE;
      band_reg     <= 1'b0;
      addr_reg     <= 5'h00;
      wr_reg       <= 1'b0;
      rd_reg       <= 1'b0;
      wdata_reg    <= 32'h0000_0000;
      busy_out     <= 1'b0;
      done_out     <= 1'b0;
      code_err_out <= 1'b0;
      first_loop_locked_flag_out  <= 1'b0;
      second_loop_locked_flag_out <= 1'b0;
      subcode_out  <= 2'h0;
    end else begin
      wr_reg       <= 1'b0;
      rd_reg       <= 1'b0;
      done_out     <= 1'b0;
      code_err_out <= 1'b0;
      case (state_reg)
        IDLE: begin
          if (band_req_in) begin
            if (range_code_in > sbl_pkg::RANGE_MAX) begin
              code_err_out <= 1'b1;
            end else begin
              band_reg  <= (range_code_in >= sbl_pkg::RANGE_HIGH_FIRST);
              addr_reg  <= loop_sel_in ? sbl_pkg::ADDR_SECOND_BAND : sbl_pkg::ADDR_FIRST_BAND;
              busy_out  <= 1'b1;
              state_reg <= RD;
            end
          end else if (status_req_in) begin
            addr_reg  <= sbl_pkg::ADDR_LOCK_STATUS;
            rd_reg    <= 1'b1;
            busy_out  <= 1'b1;
            state_reg <= ST_WAIT;
          end
        end
        RD: begin
          rd_reg    <= 1'b1;
          state_reg <= RD_WAIT;
        end
        RD_WAIT: if (bus.rvalid) begin
          // Lower bits written back exactly as read
          wdata_reg <= {band_reg, bus.rdata[30:0]};
          wr_reg    <= 1'b1;
          state_reg <= WR;
        end
        WR: begin
          busy_out  <= 1'b0;
          done_out  <= 1'b1;
          state_reg <= IDLE;
        end
        ST_WAIT: if (bus.rvalid) begin
          first_loop_locked_flag_out  <= bus.rdata[sbl_pkg::FIRST_LOCK_BIT];
          second_loop_locked_flag_out <= bus.rdata[sbl_pkg::SECOND_LOCK_BIT];
          subcode_out <= bus.rdata[sbl_pkg::SUBCODE_HI:sbl_pkg::SUBCODE_LO];
          busy_out    <= 1'b0;
          done_out    <= 1'b1;
          state_reg   <= IDLE;
        end
        default: state_reg <= IDLE;
      endcase
    end
  end

  assign bus.wr_stb = wr_reg;
  assign bus.rd_stb = rd_reg;
  assign bus.addr   = addr_reg;
  assign bus.wdata  = wdata_reg;
endmodule

// ===== logic/sbl_if.sv
// Interface: register access link between host controller and register bank
`timescale 1ns/1ns
interface sbl_if;
  logic        wr_stb;
  logic        rd_stb;
  logic [4:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        rvalid;

  modport dev  (input wr_stb, input rd_stb, input addr, input wdata,
                output rdata, output rvalid);
  modport host (output wr_stb, output rd_stb, output addr, output wdata,
                input rdata, input rvalid);
endinterface

// ===== logic/sbl_pkg.sv
// Package: register map, field positions and reset values of the band and lock registers
package sbl_pkg;
  // ---------------------------------------------------------------
  // Register addresses (word index on the control bus)
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_FACTORY_WORD_A = 5'h0B;
  localparam logic [4:0] ADDR_FIRST_BAND     = 5'h0C;
  localparam logic [4:0] ADDR_FACTORY_WORD_B = 5'h0D;
  localparam logic [4:0] ADDR_SECOND_BAND    = 5'h0E;
  localparam logic [4:0] ADDR_LOCK_STATUS    = 5'h0F;
  localparam int         ADDR_W              = 5;
  localparam int         DATA_W              = 32;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BAND_BIT          = 31;
  localparam int SECOND_LOCK_BIT   = 23;
  localparam int FIRST_LOCK_BIT    = 21;
  localparam int SUBCODE_HI        = 18;
  localparam int SUBCODE_LO        = 17;
  localparam int SUBCODE_W         = 2;

  // ---------------------------------------------------------------
  // Reset values and band thresholds
  // ---------------------------------------------------------------
  localparam logic              BAND_RESET        = 1'b0;
  // Factory words vary per device; neutral defaults
  localparam logic [DATA_W-1:0] FACTORY_A_DEFAULT = 32'h0000_0000;
  localparam logic [DATA_W-1:0] FACTORY_B_DEFAULT = 32'h0000_0000;
  // Arbitrary nonzero pattern, so a host that drops a low bit is seen
  localparam logic [30:0]       BAND_LOW_DEFAULT  = 31'h1234_5678;
  // Arbitrary variant value, not any real silicon code
  localparam logic [1:0]        SUBCODE_DEFAULT   = 2'h2;
  localparam logic [4:0]        RANGE_HIGH_FIRST  = 5'h0E;
  localparam logic [4:0]        RANGE_MAX         = 5'h1B;
  localparam logic [DATA_W-1:0] READ_ZERO         = 32'h0000_0000;
endpackage

// ===== sim/sbl_assertions.sv
// Checker: bus-link assertions between host controller and register bank
`timescale 1ns/1ns
module sbl_assertions #(
  parameter logic [1:0] SUBCODE = sbl_pkg::SUBCODE_DEFAULT
) (
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [4:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic        rvalid
);
  // ------------------------------
  // Link properties
  // ------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // Status read: strobe at the lock address, answered one cycle on
  sequence status_rd;
    rd_stb && addr == sbl_pkg::ADDR_LOCK_STATUS ##1 rvalid;
  endsequence
  chk_read_answer_next: assert property (rd_stb |=> rvalid)
    else $error("read strobe not answered next cycle");
  chk_valid_has_cause: assert property (rvalid |-> $past(rd_stb))
    else $error("read valid without a read strobe");
  chk_status_subcode: assert property (status_rd |-> rdata[18:17] == SUBCODE)
    else $error("status subcode field wrong");
  // Only the two lock flags and the subcode may ever be set
  chk_status_spare_zero: assert property (status_rd |-> (rdata & 32'hFF59_FFFF) == 32'h0)
    else $error("status spare bits not zero");
  // Host must hand back the lower band bits it just read
  chk_rmw_low_bits: assert property (wr_stb |-> wdata[30:0] == rdata[30:0])
    else $error("band write altered lower bits");
  chk_write_targets: assert property (wr_stb |-> addr inside {5'h0C, 5'h0E})
    else $error("host wrote a factory or status word");
  chk_write_after_read: assert property (wr_stb |-> $past(rvalid) && !rd_stb)
    else $error("band write not preceded by a read");
  // Reset clears the answer path even while held
  chk_reset_idle: assert property (disable iff (1'b0)
    sys_rst_in |=> !rvalid && rdata == 32'h0)
    else $error("link not idle after reset");
endmodule

// ===== sim/tb_top.sv
// Testbench: host controller and register bank joined over the bus link
`timescale 1ns/1ns
module tb_top;
  logic       clk_in = 1'b0;
  logic       sys_rst_in = 1'b1;
  logic       band_req, loop_sel, status_req, lock1, lock2;
  logic [4:0] code;
  logic       busy, done, cerr, f1, f2, band1, band2;
  logic [1:0] sub;
  int         bad_count = 0;
  int         comparisons = 0;
  int         cycles = 0;
  // Codes at both edges of each band, plus the first refused code
  logic [4:0] band_codes [5] = '{5'd0, 5'd13, 5'd14, 5'd27, 5'd28};
  sbl_if bus_link ();
  sbl_bank i_sbl_bank (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .bus(bus_link),
    .first_loop_locked_flag_in(lock1), .second_loop_locked_flag_in(lock2),
    .first_loop_gain_band_bit_out(band1), .second_loop_gain_band_bit_out(band2));
  sbl_host i_sbl_host (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .bus(bus_link),
    .band_req_in(band_req), .loop_sel_in(loop_sel), .range_code_in(code),
    .status_req_in(status_req), .busy_out(busy), .done_out(done), .code_err_out(cerr),
    .first_loop_locked_flag_out(f1), .second_loop_locked_flag_out(f2), .subcode_out(sub));
  sbl_assertions i_sbl_assertions (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .wr_stb(bus_link.wr_stb), .rd_stb(bus_link.rd_stb), .addr(bus_link.addr),
    .wdata(bus_link.wdata), .rdata(bus_link.rdata), .rvalid(bus_link.rvalid));
  // ------------------------------
  // Clock, hang guard, helpers
  // ------------------------------
  always #5 clk_in = ~clk_in;
  // Whole run needs under a hundred cycles; far above that means a hang
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic check(input logic [1:0] got, input logic [1:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask
  // Requests drop after one cycle so the idle host does not start again
  task automatic wait_end(output logic err);
    err = 1'bx;
    repeat (20) begin
      @(posedge clk_in);
      #1;
      if (done === 1'b1 || cerr === 1'b1) begin
        err = cerr;
        break;
      end
      @(negedge clk_in);
      band_req = 1'b0;
      status_req = 1'b0;
    end
    @(negedge clk_in);
    band_req = 1'b0;
    status_req = 1'b0;
  endtask
  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_band(input logic sel, input logic [4:0] c);
    logic err;
    logic keep_sel;
    logic keep_other;
    logic exp_band;
    // A refused code must leave both band bits as they were
    keep_sel = sel ? band2 : band1;
    keep_other = sel ? band1 : band2;
    exp_band = (c > 5'd27) ? keep_sel : (c >= 5'd14);
    @(negedge clk_in);
    loop_sel = sel;
    code = c;
    band_req = 1'b1;
    wait_end(err);
    check({1'b0, err}, {1'b0, c > 5'd27}, "range refusal");
    check({1'b0, sel ? band2 : band1}, {1'b0, exp_band}, "band bit");
    check({1'b0, sel ? band1 : band2}, {1'b0, keep_other}, "other band bit");
    check({1'b0, busy}, 2'b00, "busy after end");
    $display("band test done, loop %0d code %0d", sel, c);
  endtask
  task automatic t_status(input logic l1, input logic l2);
    logic err;
    @(negedge clk_in);
    lock1 = l1;
    lock2 = l2;
    status_req = 1'b1;
    wait_end(err);
    check({f2, f1}, {l2, l1}, "lock flags");
    check(sub, sbl_pkg::SUBCODE_DEFAULT, "subcode");
    $display("status test done");
  endtask
  task automatic t_reset();
    @(negedge clk_in);
    sys_rst_in = 1'b1;
    repeat (3) @(negedge clk_in);
    sys_rst_in = 1'b0;
    check({band2, band1}, 2'b00, "band bits after reset");
    $display("reset test done");
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Main sequence: boundary codes on both loops, every lock combination
  initial begin
    {band_req, loop_sel, status_req, lock1, lock2} = 5'h00;
    code = 5'h00;
    t_reset();
    for (int s = 0; s < 2; s++) begin
      foreach (band_codes[k]) t_band(s[0], band_codes[k]);
    end
    // Flags follow the loops live; a later read must not show an old state
    t_status(1'b0, 1'b0);
    t_status(1'b1, 1'b0);
    t_status(1'b0, 1'b1);
    t_status(1'b1, 1'b1);
    t_status(1'b0, 1'b0);
    // Mid-run reset with both band bits set, then a fresh band change
    t_reset();
    t_band(1'b1, 5'd20);
    end_of_test();
  end
endmodule
